// file: core/gpio_irq_led.sv
// gpio interrupt status/enable and led pin select registers
//
// What this block does
// - writing a one to a gpio interrupt status bit clears that bit, unless a qualified level sets it in the same cycle.
// - enabled, pending status bits are ORed into summary bit 12 of the system status.
// - status bits track their source whether or not the pin enable is set.
// - the interrupt pin asserts for gpio only when system enable bit 12 is set.
// - bits 27:16 hold twelve read/write per-pin enables, reset to zero.
// - bits 11:0 hold twelve per-pin status flags, reset to zero.
// - gpio interrupt inputs are level sensitive and must stand at least 40 ns.
// - led config bits 7:0 pick gpio (0) or led (1) use for the low eight pins.
// - led config bits 9:8 pick the led function, valid only on led-enabled pins.
// - led field defaults come from straps caught at reset release.
// - the eeprom loader may override the captured strap values after reset.
// - gpio interrupt register sits at 1E8h and led config at 1BCh.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module gpio_irq_led (
	// clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          rst_n_i,
	// register port
	input  wire gpio_irq_led_pkg::reg_req_type req_i,
	output logic [31:0]                        rdata_o,
	// gpio interrupt event levels from pin conditioning
	input  wire logic [11:0]                   gpio_event_i,
	// straps and eeprom loader override
	input  wire logic [1:0]                    indicator_function_strap_i,
	input  wire logic [7:0]                    indicator_select_strap_i,
	input  wire logic                          loader_valid_i,
	input  wire logic [1:0]                    loader_function_i,
	input  wire logic [7:0]                    loader_select_i,
	// outputs
	output logic [1:0]                         indicator_function_sel_o,
	output logic [7:0]                         indicator_pin_select_o,
	output logic [11:0]                        system_irq_status_o,
	output logic                               irq_o
);
	import gpio_irq_led_pkg::*;

	// address match, shared by every write and read decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b);
		hit = (a == b);
	endfunction : hit

	// write strobe aimed at one register
	function automatic logic wr_hit(input reg_req_type r,
		input logic [ADDR_W-1:0] b);
		wr_hit = r.wr && hit(r.addr, b);
	endfunction : wr_hit

	// read strobe aimed at one register
	function automatic logic rd_hit(input reg_req_type r,
		input logic [ADDR_W-1:0] b);
		rd_hit = r.rd && hit(r.addr, b);
	endfunction : rd_hit

	// event path
	logic [11:0] ev_meta_q;
	logic [11:0] ev_sync_q;
	logic [11:0] ev_level;
	// interrupt registers
	logic [11:0] sts_q;
	logic [11:0] sts_clr;
	logic [11:0] en_q;
	logic        sys_en_q;
	logic        summary;
	// write decodes
	logic        wr_gpio;
	logic        wr_led;
	logic        wr_sys_en;
	// led configuration and strap capture
	led_pin_config_type strap_in_meta_q;
	led_pin_config_type strap_in_sync_q;
	led_pin_config_type led_q;
	logic [2:0]  strap_meta_q;
	logic        strap_done_q;
	logic        strap_take;
	// read path
	logic        rd_gpio;
	logic        rd_led;
	logic        rd_sys_sts;
	logic        rd_sys_en;
	logic [31:0] rdata_d;

	// pins are asynchronous: two flops before any use
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_meta_q <= '0;
		end else begin
			ev_meta_q <= gpio_event_i;
		end
	end

	// only this flop reads the first stage
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_sync_q <= '0;
		end else begin
			ev_sync_q <= ev_meta_q;
		end
	end

	// write decodes
	assign wr_gpio   = wr_hit(req_i, GPIO_IRQ_ADDR);
	assign wr_led    = wr_hit(req_i, LED_PIN_CONFIG_ADDR);
	assign wr_sys_en = wr_hit(req_i, SYS_EN_ADDR);

	// write-one-to-clear mask; zero bits leave status alone
	always_comb begin
		sts_clr = '0;
		if (wr_gpio) begin
			sts_clr = req_i.wdata[IRQ_STS_LSB +: PIN_COUNT];
		end
	end

	// per pin: a level must stand MIN_LEVEL_CYC synced cycles, so
	// glitches shorter than the minimum width never set a flag
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_level
			logic [2:0] cnt_q;

			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cnt_q <= '0;
				end else if (!ev_sync_q[g]) begin
					cnt_q <= '0;
				end else if (cnt_q != 3'(MIN_LEVEL_CYC)) begin
					cnt_q <= cnt_q + 3'h1;
				end
			end

			assign ev_level[g] = (cnt_q == 3'(MIN_LEVEL_CYC));
		end
	endgenerate

	// per pin sticky flag; a set in the clearing cycle wins, so a
	// level that still stands is never lost
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_flag
			logic flag_q;

			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					flag_q <= IRQ_STS_RESET[g];
				end else if (ev_level[g]) begin
					flag_q <= 1'b1;
				end else if (sts_clr[g]) begin
					flag_q <= 1'b0;
				end
			end

			assign sts_q[g] = flag_q;
		end
	endgenerate

	// enables are plain read/write bits
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_q <= IRQ_EN_RESET;
		end else if (wr_gpio) begin
			en_q <= req_i.wdata[IRQ_EN_LSB +: PIN_COUNT];
		end
	end

	// system-level gpio enable
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_en_q <= SYS_EN_RESET;
		end else if (wr_sys_en) begin
			sys_en_q <= req_i.wdata[SYS_GPIO_BIT];
		end
	end

	// enables gate only the summary, never the status flags;
	// software still sees a disabled pin's event when it polls
	assign summary = |(sts_q & en_q);

	// straps are pins too and pass two flops like the gpio event inputs
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_in_meta_q <= '0;
		end else begin
			strap_in_meta_q.func    <= indicator_function_strap_i;
			strap_in_meta_q.pin_sel <= indicator_select_strap_i;
		end
	end

	// only this flop reads the first strap stage
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_in_sync_q <= '0;
		end else begin
			strap_in_sync_q <= strap_in_meta_q;
		end
	end

	// counts the first edges after reset release; by the third the
	// synced straps are settled and safe to capture
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_meta_q <= '0;
		end else begin
			strap_meta_q <= {strap_meta_q[1:0], 1'b1};
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_done_q <= 1'b0;
		end else if (strap_meta_q[2]) begin
			strap_done_q <= 1'b1;
		end
	end

	// one capture per reset release
	assign strap_take = strap_meta_q[2] && !strap_done_q;

	// precedence: strap capture, then loader override, then software;
	// a software write made before the capture is lost
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_q <= '0;
		end else if (strap_take) begin
			led_q <= strap_in_sync_q;
		end else if (loader_valid_i) begin
			led_q.func    <= loader_function_i;
			led_q.pin_sel <= loader_select_i;
		end else if (wr_led) begin
			led_q.func    <= req_i.wdata[LED_FUN_LSB +: 2];
			led_q.pin_sel <= req_i.wdata[LED_SEL_LSB +: LED_COUNT];
		end
	end

	// read decodes
	assign rd_gpio    = rd_hit(req_i, GPIO_IRQ_ADDR);
	assign rd_led     = rd_hit(req_i, LED_PIN_CONFIG_ADDR);
	assign rd_sys_sts = rd_hit(req_i, SYS_IRQ_ADDR);
	assign rd_sys_en  = rd_hit(req_i, SYS_EN_ADDR);

	// reserved bits and unmapped addresses read as zero
	always_comb begin
		rdata_d = '0;
		if (rd_gpio) begin
			rdata_d[IRQ_STS_LSB +: PIN_COUNT] = sts_q;
			rdata_d[IRQ_EN_LSB +: PIN_COUNT]  = en_q;
		end else if (rd_led) begin
			rdata_d[LED_FUN_LSB +: 2]         = led_q.func;
			rdata_d[LED_SEL_LSB +: LED_COUNT] = led_q.pin_sel;
		end else if (rd_sys_sts) begin
			rdata_d[SYS_GPIO_BIT] = summary;
		end else if (rd_sys_en) begin
			rdata_d[SYS_GPIO_BIT] = sys_en_q;
		end
	end

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// level output; follows status and enables one cycle later
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= summary & sys_en_q;
		end
	end

	// copy of the gpio status flags
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			system_irq_status_o <= '0;
		end else begin
			system_irq_status_o <= sts_q;
		end
	end

	// function only matters on pins chosen as led
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			indicator_function_sel_o <= '0;
		end else begin
			indicator_function_sel_o <= led_q.func;
		end
	end

	// per-pin gpio or led choice
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			indicator_pin_select_o <= '0;
		end else begin
			indicator_pin_select_o <= led_q.pin_sel;
		end
	end
endmodule : gpio_irq_led
`default_nettype wire

// file: inc/gpio_irq_led_pkg.sv
// package: register map, field layout and types for the gpio interrupt and led select block
package gpio_irq_led_pkg;
	localparam int          ADDR_W           = 12;
	localparam int          PIN_COUNT        = 12;
	localparam int          LED_COUNT        = 8;
	localparam logic [11:0] LED_PIN_CONFIG_ADDR     = 12'h1BC;
	localparam logic [11:0] GPIO_IRQ_ADDR    = 12'h1E8;
	localparam logic [11:0] SYS_IRQ_ADDR     = 12'h1F0;
	localparam logic [11:0] SYS_EN_ADDR      = 12'h1F4;
	localparam int          IRQ_STS_LSB      = 0;
	localparam int          IRQ_EN_LSB       = 16;
	localparam int          LED_SEL_LSB      = 0;
	localparam int          LED_FUN_LSB      = 8;
	localparam int          SYS_GPIO_BIT     = 12;
	localparam logic [11:0] IRQ_STS_RESET    = 12'h000;
	localparam logic [11:0] IRQ_EN_RESET     = 12'h000;
	localparam logic        SYS_EN_RESET     = 1'b0;
	localparam int          MIN_LEVEL_NS     = 40;
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          MIN_LEVEL_CYC    = (MIN_LEVEL_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} reg_req_type;

	typedef struct packed {
		logic [1:0] func;
		logic [7:0] pin_sel;
	} led_pin_config_type;
endpackage : gpio_irq_led_pkg

// file: sim/gpio_irq_led_monitor.sv
// checker: port assertions for the gpio interrupt and led select block
`timescale 1ns/10ps
`default_nettype none
module gpio_irq_led_monitor
	import gpio_irq_led_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire reg_req_type req_i,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0]  indicator_function_sel_o,
	input wire logic [7:0]  indicator_pin_select_o,
	input wire logic [11:0] system_irq_status_o,
	input wire logic        irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire rd_sts = req_i.rd && req_i.addr == GPIO_IRQ_ADDR;
	wire rd_led = req_i.rd && req_i.addr == LED_PIN_CONFIG_ADDR;
	wire wr_sts = req_i.wr && req_i.addr == GPIO_IRQ_ADDR;
	wire sys_off = req_i.wr && req_i.addr == SYS_EN_ADDR
		&& !req_i.wdata[SYS_GPIO_BIT];
	wire mapped = rd_sts || rd_led || req_i.addr == SYS_IRQ_ADDR
		|| req_i.addr == SYS_EN_ADDR;
	AST_RDATA_IDLE: assert property (!req_i.rd |=> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	AST_UNMAPPED: assert property (req_i.rd && !mapped |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_GPIO_RSVD: assert property (rd_sts |=>
		!(|{rdata_o[31:28], rdata_o[15:12]}))
		else $error("reserved status bits not zero");
	AST_STS_READ: assert property (rd_sts |=>
		rdata_o[11:0] == system_irq_status_o)
		else $error("status read differs");
	AST_LED_READ: assert property (rd_led |=> rdata_o == {22'h0,
		indicator_function_sel_o, indicator_pin_select_o})
		else $error("led config read differs");
	AST_EN_RW: assert property (wr_sts ##1 rd_sts |=>
		rdata_o[27:16] == $past(req_i.wdata[27:16], 2))
		else $error("enable readback differs");
	AST_SYS_GATE: assert property (sys_off |-> ##2 !irq_o)
		else $error("irq with system gpio enable clear");
	AST_IRQ_CAUSE: assert property (irq_o |->
		system_irq_status_o != 12'h000)
		else $error("irq without pending status");
	cover property (irq_o);
	cover property (rd_sts ##1 rdata_o[11:0] != 12'h0);
	cover property (req_i.wr && req_i.addr == LED_PIN_CONFIG_ADDR);
endmodule : gpio_irq_led_monitor
bind gpio_irq_led gpio_irq_led_monitor mon (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o),
	.indicator_function_sel_o(indicator_function_sel_o),
	.indicator_pin_select_o(indicator_pin_select_o),
	.system_irq_status_o(system_irq_status_o));
`default_nettype wire

// file: sim/test_gpio_irq_led.sv
// testbench: random and corner checks of the gpio interrupt and led block
`timescale 1ns/10ps
`default_nettype none
module test_gpio_irq_led;
	import gpio_irq_led_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	reg_req_type req_i = '0;
	logic [11:0] ev = 12'h000;
	logic        lv = 1'b0;
	logic [31:0] cfg = 32'h0;
	logic [31:0] r, v, rdo;
	logic [1:0]  fun_o;
	logic [7:0]  sel_o;
	logic [11:0] sts_o;
	logic        irq_o;
	integer      seed, fails = 0, check_count = 0;
	gpio_irq_led dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
		.rdata_o(rdo), .gpio_event_i(ev), .indicator_function_strap_i(cfg[1:0]),
		.indicator_select_strap_i(cfg[9:2]), .loader_valid_i(lv),
		.loader_function_i(cfg[11:10]), .loader_select_i(cfg[19:12]),
		.indicator_function_sel_o(fun_o), .indicator_pin_select_o(sel_o),
		.system_irq_status_o(sts_o), .irq_o(irq_o));
	initial forever #5 clock_i = ~clock_i;
	task chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i);
		req_i.wr <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a);
		@(posedge clock_i);
		req_i <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock_i);
		req_i.rd <= 1'b0;
		#1 v = rdo;
	endtask : rd
	// write then read with no idle cycle between the two strobes
	task wr_rd(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i);
		req_i <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock_i);
		req_i.rd <= 1'b0;
		#1 v = rdo;
	endtask : wr_rd
	// level held n cycles, then time to pass the synchroniser and qualifier
	task pulse(input int k, n);
		@(posedge clock_i);
		ev <= 12'h1 << k;
		repeat (n) @(posedge clock_i);
		ev <= 12'h000;
		repeat (12) @(posedge clock_i);
		#1;
	endtask : pulse
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		seed = 51659;
		cfg = $random(seed);
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		#1 chk("strap", {22'h0, cfg[1:0], cfg[9:2]}, {22'h0, fun_o, sel_o});
		rd(LED_PIN_CONFIG_ADDR);
		chk("led_pin_config", {22'h0, cfg[1:0], cfg[9:2]}, v);
		@(posedge clock_i);
		lv <= 1'b1;
		@(posedge clock_i);
		lv <= 1'b0;
		@(posedge clock_i);
		#1 chk("loader", {22'h0, cfg[11:10], cfg[19:12]}, {22'h0, fun_o, sel_o});
		r = $random(seed);
		wr(LED_PIN_CONFIG_ADDR, r);
		rd(LED_PIN_CONFIG_ADDR);
		chk("led rw", {22'h0, r[9:0]}, v);
		wr_rd(GPIO_IRQ_ADDR, r);
		chk("enable", {4'h0, r[27:16], 16'h0}, v);
		wr(SYS_EN_ADDR, 32'h1000);
		for (int k = 0; k < 12; k++) begin
			pulse(k, 10);
			chk("status", 32'h1 << k, {20'h0, sts_o});
			chk("irq", {31'h0, r[16+k]}, {31'h0, irq_o});
			wr(GPIO_IRQ_ADDR, {4'h0, r[27:16], 16'h0});
			rd(GPIO_IRQ_ADDR);
			chk("kept", {4'h0, r[27:16], 4'h0, 12'h1 << k}, v);
			wr(GPIO_IRQ_ADDR, {4'h0, r[27:16], 4'h0, 12'h1 << k});
			repeat (2) @(posedge clock_i);
			#1 chk("cleared", 32'h0, {20'h0, sts_o});
			$display("pin %0d done", k);
		end
		wr(SYS_EN_ADDR, 32'h0);
		wr(GPIO_IRQ_ADDR, 32'h0FFF0000);
		pulse(4, 10);
		chk("gated", 32'h0, {31'h0, irq_o});
		rd(SYS_IRQ_ADDR);
		chk("summary", 32'h1000, v);
		wr(SYS_EN_ADDR, 32'h1000);
		repeat (2) @(posedge clock_i);
		#1 chk("ungated", 32'h1, {31'h0, irq_o});
		wr(GPIO_IRQ_ADDR, 32'h0FFF0FFF);
		pulse(5, 2);
		chk("short", 32'h0, {20'h0, sts_o});
		rd(12'h1EC);
		chk("unmapped", 32'h0, v);
		print_verdict();
	end
endmodule : test_gpio_irq_led
`default_nettype wire
